// ==== pkg/sbc_pkg.sv ====
// constants for the serial bus configuration and timeout block
// assumes a 25 MHz system clock and Avalon-MM register access
package sbc_pkg;
    // register byte addresses
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_CFG = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
    // configuration register fields
    localparam int CFG_W = 8;
    localparam int CFG_EN_BIT = 7;
    localparam int CFG_INH_BIT = 6;
    localparam int CFG_BUSY_BIT = 5;
    localparam int CFG_EXT_BIT = 4;
    localparam int CFG_TOE_BIT = 3;
    localparam int CFG_FTE_BIT = 2;
    localparam int CFG_CS_LSB = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WR_MASK = 8'hdf;
    // clock source codes
    localparam logic [1:0] CS_T0 = 2'h0;
    localparam logic [1:0] CS_T1 = 2'h1;
    localparam logic [1:0] CS_T2_HI = 2'h2;
    localparam logic [1:0] CS_T2_LO = 2'h3;
    // interrupt status and mask layout
    localparam int IRQ_W = 5;
    localparam int IRQ_START = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_FREE = 2;
    localparam int IRQ_SLAVE = 3;
    localparam int IRQ_MASTER = 4;
    localparam logic [4:0] IRQ_RESET = 5'h00;
    // timing counts in system clocks
    localparam int CNT_W = 4;
    localparam logic [3:0] HOLD_STD_CLKS = 4'h3;
    localparam logic [3:0] HOLD_EXT_CLKS = 4'hc;
    localparam logic [3:0] SETUP_STD_CLKS = 4'h1;
    localparam logic [3:0] SETUP_EXT_CLKS = 4'hb;
    // bus free after more than this many source periods
    localparam int FREE_PERIODS = 10;
    typedef enum logic {BUS_IDLE, BUS_BUSY} sbc_bus_e;
endpackage

// ==== pkg/sbc_mon_if.sv ====
// signals between the control core and the bus line monitor
// assumes both ends run on the system clock
`timescale 1ns/1ps
interface sbc_mon_if;
    logic enable;
    logic fte;
    logic tick;
    logic scl;
    logic sda;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic free_pulse;
    modport mon (input enable, fte, tick,
                 output scl, sda, scl_fall, start_det, stop_det, free_pulse);
    modport core (output enable, fte, tick,
                  input scl, sda, scl_fall, start_det, stop_det, free_pulse);
endinterface

// ==== rtl/sbc_line_mon.sv ====
// bus line monitor: synchronisers, start/stop detection, free timeout
// assumes scl and sda pins are asynchronous to i_sys_clk
`timescale 1ns/1ps
module sbc_line_mon #(
    parameter int FREE_W = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    sbc_mon_if.mon mon
);
    generate
        if (FREE_W < 1 || (2 ** FREE_W) <= sbc_pkg::FREE_PERIODS + 1) begin : g_chk
            $error("free counter too narrow");
        end
    endgenerate

    localparam logic [FREE_W-1:0] FREE_LIM = FREE_W'(sbc_pkg::FREE_PERIODS);

    logic scl_m_reg, scl_s_reg, scl_d_reg;
    logic sda_m_reg, sda_s_reg, sda_d_reg;
    logic [FREE_W-1:0] free_cnt_reg, free_cnt_next;
    logic start_reg, stop_reg, fall_reg, free_reg;

    wire both_high = scl_s_reg & sda_s_reg;
    wire start_w = mon.enable & scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
    wire stop_w = mon.enable & scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
    wire fall_w = mon.enable & scl_d_reg & ~scl_s_reg;
    wire free_w = mon.enable & mon.fte & both_high & mon.tick & (free_cnt_reg == FREE_LIM);

    // count source periods while both lines stay high
    always_comb begin
        free_cnt_next = free_cnt_reg;
        if (!mon.enable || !both_high) begin
            free_cnt_next = '0;
        end else if (mon.tick && free_cnt_reg <= FREE_LIM) begin
            free_cnt_next = free_cnt_reg + FREE_W'(1);
        end
    end

    // two-stage synchronisers, then one delay stage for edges
    always_ff @(posedge i_sys_clk) begin
        scl_m_reg <= i_scl;
        scl_s_reg <= scl_m_reg;
        scl_d_reg <= scl_s_reg;
        sda_m_reg <= i_sda;
        sda_s_reg <= sda_m_reg;
        sda_d_reg <= sda_s_reg;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            free_cnt_reg <= '0;
            start_reg <= 1'b0;
            stop_reg <= 1'b0;
            fall_reg <= 1'b0;
            free_reg <= 1'b0;
        end else begin
            free_cnt_reg <= free_cnt_next;
            start_reg <= start_w;
            stop_reg <= stop_w;
            fall_reg <= fall_w;
            free_reg <= free_w;
        end
    end

    assign mon.scl = scl_s_reg;
    assign mon.sda = sda_s_reg;
    assign mon.scl_fall = fall_reg;
    assign mon.start_det = start_reg;
    assign mon.stop_det = stop_reg;
    assign mon.free_pulse = free_reg;
endmodule

// ==== rtl/sbc_top.sv ====
// serial bus configuration, busy tracking, line timing and timeouts
// assumes an Avalon-MM master on i_sys_clk and open-drain scl/sda pads
// Summary of operation
// - the interface works only while the enable bit is one
// - while enabled both bus lines are sampled and tracked constantly
// - slave inhibit set blocks every slave event interrupt
// - master event interrupts stay unaffected by slave inhibit
// - read-only busy bit goes high while a transfer is in progress
// - busy clears on a stop condition or on bus free timeout
// - hold extension bit selects standard or extended setup and hold
// - hold 3 clocks normally; extended gives 11 setup and 12 hold clocks
// - clock low timeout detection is armed by its enable bit while the interface is enabled
// - armed timeout timer reloads while clock high, counts while low
// - in split timer mode only the upper byte is held in reload
// - bus free when both lines high over 10 source periods
// - source field picks timer 0, timer 1 or one of two timer 2 overflows
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
module sbc_top (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_oe,
    output logic o_sda_oe,
    // transfer engine requests and events
    input wire logic i_scl_low_req,
    input wire logic i_sda_low_req,
    input wire logic i_slave_event,
    input wire logic i_master_event,
    // timer overflows and timeout timer control
    input wire logic i_t0_ovf,
    input wire logic i_t1_ovf,
    input wire logic i_t2_ovf_hi,
    input wire logic i_t2_ovf_lo,
    input wire logic i_tmr_split,
    output logic o_tmr_reload_full,
    output logic o_tmr_reload_hi,
    output logic o_tmr_count_en,
    // status to the rest of the interface
    output logic o_iface_en,
    output logic o_bitrate_tick,
    output logic o_bus_busy,
    output logic o_start_det,
    output logic o_stop_det,
    output logic o_irq
);
    sbc_mon_if mon_bus();

    // pick standard or extended count
    function automatic logic [3:0] sel_count(input logic ext, input logic [3:0] std_c,
                                             input logic [3:0] ext_c);
        sel_count = ext ? ext_c : std_c;
    endfunction

    logic [7:0] cfg_reg, cfg_next;
    logic [4:0] irq_stat_reg, irq_stat_next;
    logic [4:0] irq_mask_reg, irq_mask_next;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;
    sbc_pkg::sbc_bus_e bus_reg, bus_next;
    logic [3:0] hold_cnt_reg, hold_cnt_next;
    logic [3:0] setup_cnt_reg, setup_cnt_next;
    logic scl_oe_reg, scl_oe_next;
    logic sda_oe_reg, sda_oe_next;
    logic tick_reg;
    logic reload_full_reg, reload_hi_reg, count_en_reg;
    logic start_reg, stop_reg;

    // configuration fields
    wire iface_en = cfg_reg[sbc_pkg::CFG_EN_BIT];
    wire inhibit = cfg_reg[sbc_pkg::CFG_INH_BIT];
    wire hold_ext = cfg_reg[sbc_pkg::CFG_EXT_BIT];
    wire toe = iface_en & cfg_reg[sbc_pkg::CFG_TOE_BIT];
    wire fte = iface_en & cfg_reg[sbc_pkg::CFG_FTE_BIT];
    wire [1:0] cs_sel = cfg_reg[sbc_pkg::CFG_CS_LSB +: 2];

    // register access decode
    wire req = i_avs_read | i_avs_write;
    wire acc_done = req & ~wait_reg;
    wire wr_done = acc_done & i_avs_write;
    wire hit_cfg = (i_avs_address == sbc_pkg::ADDR_CFG);
    wire hit_stat = (i_avs_address == sbc_pkg::ADDR_IRQ_STAT);
    wire hit_mask = (i_avs_address == sbc_pkg::ADDR_IRQ_MASK);
    wire wr_cfg = wr_done & hit_cfg;
    wire wr_stat = wr_done & hit_stat;
    wire wr_mask = wr_done & hit_mask;
    wire [7:0] cfg_view = {cfg_reg[7:6], (bus_reg == sbc_pkg::BUS_BUSY), cfg_reg[4:0]};
    wire [31:0] rd_mux = hit_cfg ? {24'h0, cfg_view} :
                         hit_stat ? {27'h0, irq_stat_reg} :
                         hit_mask ? {27'h0, irq_mask_reg} : 32'h0;

    // bit rate source selection
    wire tick_w = iface_en & ((cs_sel == sbc_pkg::CS_T0) ? i_t0_ovf :
                              (cs_sel == sbc_pkg::CS_T1) ? i_t1_ovf :
                              (cs_sel == sbc_pkg::CS_T2_HI) ? i_t2_ovf_hi : i_t2_ovf_lo);

    // events, slave ones gated by inhibit
    wire free_ev = mon_bus.free_pulse & fte;
    wire [4:0] ev_vec = {iface_en & i_master_event,
                         iface_en & i_slave_event & ~inhibit,
                         free_ev,
                         mon_bus.stop_det,
                         mon_bus.start_det};

    assign mon_bus.enable = iface_en;
    assign mon_bus.fte = fte;
    assign mon_bus.tick = tick_reg;

    sbc_line_mon #(
        .FREE_W(sbc_pkg::CNT_W)
    ) u_mon (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .mon(mon_bus)
    );

    // register next values; event set wins over clear
    always_comb begin
        cfg_next = cfg_reg;
        irq_mask_next = irq_mask_reg;
        if (wr_cfg) begin
            cfg_next = i_avs_writedata[7:0] & sbc_pkg::CFG_WR_MASK;
        end
        if (wr_mask) begin
            irq_mask_next = i_avs_writedata[4:0];
        end
        irq_stat_next = irq_stat_reg;
        if (wr_stat) begin
            irq_stat_next = irq_stat_reg & ~i_avs_writedata[4:0];
        end
        irq_stat_next = irq_stat_next | ev_vec;
    end

    // bus busy tracking
    always_comb begin
        bus_next = bus_reg;
        case (bus_reg)
            sbc_pkg::BUS_IDLE: begin
                if (mon_bus.start_det) begin
                    bus_next = sbc_pkg::BUS_BUSY;
                end
            end
            sbc_pkg::BUS_BUSY: begin
                if (mon_bus.stop_det || free_ev) begin
                    bus_next = sbc_pkg::BUS_IDLE;
                end
            end
            default: begin
                bus_next = sbc_pkg::BUS_IDLE;
            end
        endcase
        if (!iface_en) begin
            bus_next = sbc_pkg::BUS_IDLE;
        end
    end

    // own scl pull opens the hold window at once, without the sync lag
    wire own_scl_fall = iface_en & i_scl_low_req & ~scl_oe_reg;

    // sda hold after scl fall, scl release after sda setup
    always_comb begin
        hold_cnt_next = hold_cnt_reg;
        setup_cnt_next = setup_cnt_reg;
        sda_oe_next = sda_oe_reg;
        if (mon_bus.scl_fall || own_scl_fall) begin
            hold_cnt_next = sel_count(hold_ext, sbc_pkg::HOLD_STD_CLKS,
                                      sbc_pkg::HOLD_EXT_CLKS);
        end else if (hold_cnt_reg != 4'h0) begin
            hold_cnt_next = hold_cnt_reg - 4'h1;
        end
        if (hold_cnt_reg == 4'h0 && !mon_bus.scl_fall && !own_scl_fall) begin
            sda_oe_next = i_sda_low_req;
        end
        if (sda_oe_next != sda_oe_reg) begin
            setup_cnt_next = sel_count(hold_ext, sbc_pkg::SETUP_STD_CLKS,
                                       sbc_pkg::SETUP_EXT_CLKS);
        end else if (setup_cnt_reg != 4'h0) begin
            setup_cnt_next = setup_cnt_reg - 4'h1;
        end
        scl_oe_next = i_scl_low_req | (scl_oe_reg & (setup_cnt_reg != 4'h0));
        if (!iface_en) begin
            sda_oe_next = 1'b0;
            scl_oe_next = 1'b0;
            hold_cnt_next = 4'h0;
            setup_cnt_next = 4'h0;
        end
    end

    // avalon slave: one wait cycle, then the access completes
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
        end else begin
            wait_reg <= ~(req & wait_reg);
            rdata_reg <= (i_avs_read & wait_reg) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cfg_reg <= sbc_pkg::CFG_RESET;
            irq_stat_reg <= sbc_pkg::IRQ_RESET;
            irq_mask_reg <= sbc_pkg::IRQ_RESET;
            irq_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            bus_reg <= sbc_pkg::BUS_IDLE;
            hold_cnt_reg <= 4'h0;
            setup_cnt_reg <= 4'h0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else begin
            bus_reg <= bus_next;
            hold_cnt_reg <= hold_cnt_next;
            setup_cnt_reg <= setup_cnt_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
        end
    end

    // timeout timer control and status strobes
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            tick_reg <= 1'b0;
            reload_full_reg <= 1'b0;
            reload_hi_reg <= 1'b0;
            count_en_reg <= 1'b0;
            start_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else begin
            tick_reg <= tick_w;
            reload_full_reg <= toe & mon_bus.scl & ~i_tmr_split;
            reload_hi_reg <= toe & mon_bus.scl;
            count_en_reg <= toe & ~mon_bus.scl;
            start_reg <= mon_bus.start_det;
            stop_reg <= mon_bus.stop_det;
        end
    end

    assign o_avs_readdata = rdata_reg;
    assign o_avs_waitrequest = wait_reg;
    assign o_scl_oe = scl_oe_reg;
    assign o_sda_oe = sda_oe_reg;
    assign o_tmr_reload_full = reload_full_reg;
    assign o_tmr_reload_hi = reload_hi_reg;
    assign o_tmr_count_en = count_en_reg;
    assign o_iface_en = cfg_reg[sbc_pkg::CFG_EN_BIT];
    assign o_bitrate_tick = tick_reg;
    assign o_bus_busy = (bus_reg == sbc_pkg::BUS_BUSY);
    assign o_start_det = start_reg;
    assign o_stop_det = stop_reg;
    assign o_irq = irq_reg;
endmodule

// ==== tb/sbc_bus_model.sv ====
// other bus device: pulls the open-drain lines low on command
// assumes pull-ups on both lines and a 320 ns bit period
`timescale 1ns/1ps
module sbc_bus_model (
    output logic o_scl_low,
    output logic o_sda_low
);
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    // sda falls under high scl, then scl low
    task automatic start();
        #7 o_sda_low = 1'b1;
        #160 o_scl_low = 1'b1;
        #160;
    endtask
    // sda low under low scl, scl up, sda rises
    task automatic stop();
        #7 o_sda_low = 1'b1;
        #160 o_scl_low = 1'b0;
        #160 o_sda_low = 1'b0;
        #160;
    endtask
    // lines released with no stop
    task automatic drop();
        #7 o_sda_low = 1'b0;
        #160 o_scl_low = 1'b0;
        #160;
    endtask
endmodule

// ==== tb/sbc_checker.sv ====
// port assertions for the configuration and timeout block
// assumes one system clock domain, bound to sbc_top
`timescale 1ns/1ps
module sbc_checker (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic i_scl,
    input wire logic o_scl_oe,
    input wire logic o_sda_oe,
    input wire logic i_t0_ovf,
    input wire logic i_t1_ovf,
    input wire logic i_t2_ovf_hi,
    input wire logic i_t2_ovf_lo,
    input wire logic i_tmr_split,
    input wire logic o_tmr_reload_full,
    input wire logic o_tmr_reload_hi,
    input wire logic o_tmr_count_en,
    input wire logic o_iface_en,
    input wire logic o_bitrate_tick,
    input wire logic o_bus_busy,
    input wire logic o_start_det,
    input wire logic o_stop_det
);
    logic [2:0] scl_hist;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            scl_hist <= 3'h7;
        end else begin
            scl_hist <= {scl_hist[1:0], i_scl};
        end
    end
    wire recent_fall = (scl_hist[0] & ~i_scl) | (scl_hist[1] & ~scl_hist[0])
        | (scl_hist[2] & ~scl_hist[1]);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    sequence scl_low6;
        !i_scl [*6];
    endsequence
    a_wait_pulse: assert property ($fell(o_avs_waitrequest) |->
        $past(i_avs_read || i_avs_write) ##1 o_avs_waitrequest) else $error("wait pulse");
    a_off_quiet: assert property (!o_iface_en && !$past(o_iface_en) && !$past(o_iface_en, 2)
        |-> !(o_scl_oe || o_sda_oe || o_start_det || o_stop_det || o_bus_busy || o_bitrate_tick
        || o_tmr_reload_hi || o_tmr_count_en)) else $error("active while off");
    a_tick_cause: assert property (o_bitrate_tick |-> $past(i_t0_ovf) || $past(i_t1_ovf)
        || $past(i_t2_ovf_hi) || $past(i_t2_ovf_lo)) else $error("tick without overflow");
    a_timer_excl: assert property (!(o_tmr_count_en && o_tmr_reload_hi))
        else $error("timer counts in reload");
    a_timer_count: assert property (scl_low6 ##0 (o_tmr_reload_hi || o_tmr_count_en)
        |-> o_tmr_count_en) else $error("timer not counting");
    a_split_full: assert property (o_tmr_reload_full |-> o_tmr_reload_hi
        && !$past(i_tmr_split)) else $error("full reload in split");
    a_busy_start: assert property (o_start_det |-> o_bus_busy) else $error("busy late");
    a_busy_cause: assert property ($rose(o_bus_busy) |-> o_start_det)
        else $error("busy without start");
    a_busy_stop: assert property (o_stop_det |-> !o_bus_busy) else $error("busy after stop");
    a_hold_min: assert property (o_iface_en && $changed(o_sda_oe) |-> !recent_fall)
        else $error("sda hold short");
endmodule
bind sbc_top sbc_checker sbc_checker_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
    .i_scl(i_scl), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .i_t0_ovf(i_t0_ovf),
    .i_t1_ovf(i_t1_ovf), .i_t2_ovf_hi(i_t2_ovf_hi), .i_t2_ovf_lo(i_t2_ovf_lo),
    .i_tmr_split(i_tmr_split), .o_tmr_reload_full(o_tmr_reload_full),
    .o_tmr_reload_hi(o_tmr_reload_hi), .o_tmr_count_en(o_tmr_count_en),
    .o_iface_en(o_iface_en), .o_bitrate_tick(o_bitrate_tick), .o_bus_busy(o_bus_busy),
    .o_start_det(o_start_det), .o_stop_det(o_stop_det));

// ==== tb/tb_top.sv ====
// self-checking bench for the configuration and timeout block
// assumes sbc_pkg, the bus model and the checker are compiled first
`timescale 1ns/1ps
module tb_top;
    localparam logic [3:0] A_CFG = sbc_pkg::ADDR_CFG;
    localparam logic [3:0] A_ST = sbc_pkg::ADDR_IRQ_STAT;
    localparam logic [3:0] A_MK = sbc_pkg::ADDR_IRQ_MASK;
    logic clk, rst_n, rd, wr, split, avs_wait, sda_oe, scl_oe, m_scl, m_sda;
    logic rl_full, rl_hi, cnt_en, iface_en, tick, busy, st_det, sp_det, irq;
    logic [3:0] addr, ovf;
    logic [1:0] ev, lreq;
    logic [31:0] wdata, rdata, rv;
    int bad_count = 0;
    int checked = 0;
    int ticks = 0;
    int starts = 0;
    int stops = 0;
    int t0;
    wire scl = ~(scl_oe | m_scl);
    wire sda = ~(sda_oe | m_sda);
    sbc_top sbc_top_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(avs_wait), .i_scl(scl), .i_sda(sda), .o_scl_oe(scl_oe),
        .o_sda_oe(sda_oe), .i_scl_low_req(lreq[1]), .i_sda_low_req(lreq[0]),
        .i_slave_event(ev[0]), .i_master_event(ev[1]), .i_t0_ovf(ovf[0]), .i_t1_ovf(ovf[1]),
        .i_t2_ovf_hi(ovf[2]), .i_t2_ovf_lo(ovf[3]), .i_tmr_split(split),
        .o_tmr_reload_full(rl_full), .o_tmr_reload_hi(rl_hi), .o_tmr_count_en(cnt_en),
        .o_iface_en(iface_en), .o_bitrate_tick(tick), .o_bus_busy(busy),
        .o_start_det(st_det), .o_stop_det(sp_det), .o_irq(irq));
    sbc_bus_model sbc_bus_model_inst (.o_scl_low(m_scl), .o_sda_low(m_sda));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (tick === 1'b1) ticks <= ticks + 1;
        if (st_det === 1'b1) starts <= starts + 1;
        if (sp_det === 1'b1) stops <= stops + 1;
    end
    task automatic summarize();
        if (bad_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic gap(input int n);
        repeat (n) @(posedge clk);
    endtask
    // avalon access held until waitrequest is seen low
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk);
        end while (avs_wait !== 1'b0);
        rv = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        gap(2);
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(nm, rv, exp);
    endtask
    task automatic pulse_ovf(input int k);
        ovf <= 4'h1 << k;
        @(posedge clk);
        ovf <= 4'h0;
        gap(3);
    endtask
    task automatic pulse_ev(input logic [1:0] v);
        ev <= v;
        @(posedge clk);
        ev <= 2'h0;
        gap(3);
    endtask
    initial begin
        #400000;
        bad_count++;
        summarize();
    end
    initial begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        ovf = 4'h0;
        ev = 2'h0;
        lreq = 2'h0;
        split = 1'b1;
        gap(16);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk("cfg reset", A_CFG, 32'h0);
        rd_chk("unmapped", 4'hc, 32'h0);
        xfer(1'b1, 4'hc, 32'hff);
        xfer(1'b1, A_CFG, 32'hff);
        rd_chk("cfg readonly busy", A_CFG, 32'hdf);
        chk("iface on", iface_en, 1'b1);
        for (int cs = 0; cs < 4; cs++) begin
            xfer(1'b1, A_CFG, 32'h80 | cs);
            for (int k = 0; k < 4; k++) begin
                t0 = ticks;
                pulse_ovf(k);
                chk("tick", ticks - t0, (k == cs) ? 32'h1 : 32'h0);
            end
        end
        xfer(1'b1, A_MK, 32'h1f);
        xfer(1'b1, A_CFG, 32'h88);
        chk("reload split high", {rl_full, rl_hi, cnt_en}, 3'b010);
        sbc_bus_model_inst.start();
        gap(8);
        chk("count low", {rl_hi, cnt_en}, 2'b01);
        chk("irq start", irq, 1'b1);
        chk("busy pin", busy, 1'b1);
        chk("start seen", starts, 32'h1);
        rd_chk("busy set", A_CFG, 32'ha8);
        rd_chk("stat start", A_ST, 32'h01);
        xfer(1'b1, A_ST, 32'h1f);
        chk("irq clear", irq, 1'b0);
        sbc_bus_model_inst.stop();
        gap(8);
        chk("stop seen", stops, 32'h1);
        chk("busy pin low", busy, 1'b0);
        rd_chk("busy stop", A_CFG, 32'h88);
        rd_chk("stat stop", A_ST, 32'h02);
        split <= 1'b0;
        gap(3);
        chk("reload full", {rl_full, rl_hi}, 2'b11);
        xfer(1'b1, A_CFG, 32'h80);
        chk("timer off", {rl_full, rl_hi, cnt_en}, 3'b000);
        xfer(1'b1, A_ST, 32'h1f);
        xfer(1'b1, A_CFG, 32'h84);
        sbc_bus_model_inst.start();
        sbc_bus_model_inst.drop();
        gap(8);
        repeat (10) pulse_ovf(0);
        rd_chk("busy ten", A_CFG, 32'ha4);
        pulse_ovf(0);
        rd_chk("busy free", A_CFG, 32'h84);
        rd_chk("stat free", A_ST, 32'h05);
        xfer(1'b1, A_ST, 32'h1f);
        xfer(1'b1, A_CFG, 32'hc0);
        pulse_ev(2'h3);
        rd_chk("stat inhibit", A_ST, 32'h10);
        xfer(1'b1, A_CFG, 32'h80);
        xfer(1'b1, A_MK, 32'h10);
        rd_chk("mask", A_MK, 32'h10);
        pulse_ev(2'h1);
        rd_chk("stat slave", A_ST, 32'h18);
        chk("irq master", irq, 1'b1);
        xfer(1'b1, A_ST, 32'h10);
        chk("irq masked", irq, 1'b0);
        lreq <= 2'h3;
        gap(20);
        chk("oe on", {scl_oe, sda_oe}, 2'b11);
        xfer(1'b1, A_CFG, 32'h00);
        gap(4);
        chk("oe off", {scl_oe, sda_oe}, 2'b00);
        chk("iface off", iface_en, 1'b0);
        xfer(1'b1, A_ST, 32'h1f);
        sbc_bus_model_inst.start();
        gap(8);
        rd_chk("off busy", A_CFG, 32'h0);
        rd_chk("off stat", A_ST, 32'h0);
        chk("off starts", starts, 32'h2);
        summarize();
    end
endmodule
